// ### hdl/host_port_pkg.sv
// Constants and types shared by the multiplexed host bus access port
package host_port_pkg;

    // Clock and operation clock periods, in picoseconds
    localparam int CLK_PERIOD_PS     = 5000;
    localparam int OPR_PERIOD_X1_PS  = 50000;
    localparam int OPR_PERIOD_X2_PS  = 25000;
    localparam int OPR_PERIOD_X4_PS  = 12500;

    // Operation clock period in system clocks, rounded up
    localparam logic [4:0] OPR_CYC_X1 = 5'((OPR_PERIOD_X1_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [4:0] OPR_CYC_X2 = 5'((OPR_PERIOD_X2_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [4:0] OPR_CYC_X4 = 5'((OPR_PERIOD_X4_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

    // Minimum spacings and counter saturation value, in arbitration clock periods
    localparam logic [2:0] CYCLE_TARB       = 3'h4;
    localparam logic [2:0] DATA_TO_PTR_TARB = 3'h5;
    localparam logic [2:0] PTR_LO_TARB      = 3'h4;
    localparam logic [2:0] TARB_SAT         = 3'h7;

    // Register offsets on the multiplexed bus
    localparam logic [2:0] REG_ADDR_HI = 3'h2;
    localparam logic [2:0] REG_ADDR_LO = 3'h3;
    localparam logic [2:0] REG_DATA    = 3'h4;
    localparam logic [2:0] REG_CONFIG  = 3'h6;
    localparam logic [2:0] REG_STATUS  = 3'h7;

    // Field positions
    localparam int CFG_RBT_BIT     = 0;
    localparam int CFG_SLOW_BIT    = 1;
    localparam int CFG_CKLO_BIT    = 2;
    localparam int CFG_CKHI_BIT    = 3;
    localparam int HI_AUTOINC_BIT  = 7;
    localparam int STS_VIOL_BIT    = 0;
    localparam int STS_BUSY_BIT    = 1;

    // Reset values
    localparam logic [7:0]  CONFIG_RST = 8'h00;
    localparam logic [10:0] PTR_RST    = 11'h000;

    // Buffer memory geometry
    localparam int RAM_AW = 11;
    localparam int RAM_DW = 8;

    typedef enum logic {RAM_IDLE, RAM_FETCH} ram_state_e;

endpackage : host_port_pkg

// ### hdl/port_ram.sv
// Buffer memory behind the data register, registered read data
`timescale 1ns/1ps
module port_ram
(
    input  wire logic                              clk,
    input  wire logic                              we,
    input  wire logic [host_port_pkg::RAM_AW-1:0]  addr,
    input  wire logic [host_port_pkg::RAM_DW-1:0]  wdata,
    output logic      [host_port_pkg::RAM_DW-1:0]  rdata
);
    import host_port_pkg::*;

    logic [RAM_DW-1:0] mem [0:(1 << RAM_AW) - 1];

    // Write port and registered read port
    always_ff @(posedge clk)
    begin
        if (we)
        begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end

endmodule : port_ram

// ### hdl/muxed_host_bus_access_port.sv
// Multiplexed host bus port with pointer, data and spacing guard logic
`timescale 1ns/1ps
module muxed_host_bus_access_port
(
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        ale,
    input  wire logic        chip_select_n,
    input  wire logic [7:0]  ad_in,
    output logic      [7:0]  ad_out,
    output logic             ad_oe,
    input  wire logic        data_strobe_mode,
    input  wire logic        data_strobe_n,
    input  wire logic        dir,
    input  wire logic        read_strobe_n,
    input  wire logic        write_strobe_n
);
    import host_port_pkg::*;

    typedef struct packed {
        logic [7:0]         ad_prev;
        logic               ale_prev;
        logic               act_prev;
        logic [2:0]         addr_lat;
        logic               sel_lat;
        logic               busy;
        logic               is_read;
        logic               ok;
        logic [2:0]         acc_addr;
        logic [7:0]         dout;
        logic [4:0]         presc;
        logic [2:0]         since_lead;
        logic [2:0]         since_trail;
        logic               last_data;
        logic               last_lo_wr;
        logic [10:0]        ptr;
        logic               autoinc;
        logic [7:0]         cfg;
        logic               viol;
        logic               pend_wr;
        logic               pend_rd;
        logic [10:0]        waddr;
        logic [7:0]         wbyte;
        logic [7:0]         prefetch;
        ram_state_e         ram_st;
    } port_state_s;

    port_state_s       r_reg;
    port_state_s       r_next;
    logic              ram_we;
    logic [10:0]       ram_addr;
    logic [7:0]        ram_rdata;
    logic              act;
    logic              rd_now;
    logic              tick;
    logic              lead;
    logic              trail;
    logic              legal;
    logic [4:0]        arb_len;

    // Operation clock period in system clocks for a multiplier setting
    function automatic logic [4:0] opr_cycles(input logic hi, input logic lo);
        logic [4:0] c;
        unique case ({hi, lo})
            2'b01:   c = OPR_CYC_X2;
            2'b10:   c = OPR_CYC_X4;
            default: c = OPR_CYC_X1;
        endcase
        return c;
    endfunction : opr_cycles

    // Spacing check for a new access against the previous one
    function automatic logic spacing_ok(input logic [2:0] addr, input logic rd,
                                        input port_state_s s);
        logic ok;
        logic ptr_rd;
        ok = (s.since_lead >= CYCLE_TARB);
        ptr_rd = rd && (addr == REG_ADDR_HI || addr == REG_ADDR_LO);
        if (s.last_lo_wr && s.since_trail < PTR_LO_TARB)
        begin
            ok = 1'b0;
        end
        if (s.last_data && (ptr_rd || (!rd && addr == REG_ADDR_LO))
            && s.since_trail < DATA_TO_PTR_TARB)
        begin
            ok = 1'b0;
        end
        return ok;
    endfunction : spacing_ok

    // Register readback mux
    function automatic logic [7:0] reg_read(input logic [2:0] addr, input port_state_s s);
        logic [7:0] v;
        v = 8'h00;
        unique case (addr)
            REG_ADDR_HI: v = {s.autoinc, 4'h0, s.ptr[10:8]};
            REG_ADDR_LO: v = s.ptr[7:0];
            REG_DATA:    v = s.prefetch;
            REG_CONFIG:  v = s.cfg;
            REG_STATUS:
            begin
                v[STS_VIOL_BIT] = s.viol;
                v[STS_BUSY_BIT] = s.pend_wr | s.pend_rd | (s.ram_st == RAM_FETCH);
            end
            default:     v = 8'h00;
        endcase
        return v;
    endfunction : reg_read

    // Strobe decode for the two control styles
    assign act    = data_strobe_mode ? ~data_strobe_n : (~read_strobe_n | ~write_strobe_n);
    assign rd_now = data_strobe_mode ? dir : ~read_strobe_n;
    assign lead   = act & ~r_reg.act_prev;
    assign trail  = ~act & r_reg.act_prev;

    // Arbitration tick from the operation clock setting
    assign arb_len = opr_cycles(r_reg.cfg[CFG_CKHI_BIT], r_reg.cfg[CFG_CKLO_BIT])
                     << r_reg.cfg[CFG_SLOW_BIT];
    // Compare with >= so that a shorter period set over a running count ticks at once
    assign tick    = (r_reg.presc >= arb_len - 5'h01);
    assign legal   = spacing_ok(r_reg.addr_lat, rd_now, r_reg);

    // Memory access follows the pending write first, else the pointer
    assign ram_we   = (r_reg.ram_st == RAM_IDLE) && tick && r_reg.pend_wr;
    assign ram_addr = r_reg.pend_wr ? r_reg.waddr : r_reg.ptr;

    // Pin outputs; bus released as soon as the strobe goes high
    assign ad_out = r_reg.dout;
    assign ad_oe  = act & r_reg.busy & r_reg.is_read & r_reg.ok;

    // Next state
    always_comb
    begin
        r_next          = r_reg;
        r_next.ad_prev  = ad_in;
        r_next.ale_prev = ale;
        r_next.act_prev = act;
        r_next.presc    = tick ? 5'h00 : r_reg.presc + 5'h01;

        // Address and select captured on the falling latch strobe
        if (r_reg.ale_prev && !ale)
        begin
            r_next.addr_lat = ad_in[2:0];
            r_next.sel_lat  = ~chip_select_n;
        end

        // Arbitration period counters, saturating
        if (tick && r_reg.since_lead != TARB_SAT)
        begin
            r_next.since_lead = r_reg.since_lead + 3'h1;
        end
        if (tick && !act && r_reg.since_trail != TARB_SAT)
        begin
            r_next.since_trail = r_reg.since_trail + 3'h1;
        end

        // Memory slot once per arbitration period; placed before the access
        // logic so that a request raised in the same cycle wins over the clear
        unique case (r_reg.ram_st)
            RAM_IDLE:
            begin
                if (tick && r_reg.pend_wr)
                begin
                    r_next.pend_wr = 1'b0;
                end
                else if (tick && r_reg.pend_rd)
                begin
                    r_next.pend_rd = 1'b0;
                    r_next.ram_st  = RAM_FETCH;
                end
            end
            RAM_FETCH:
            begin
                r_next.prefetch = ram_rdata;
                r_next.ram_st   = RAM_IDLE;
            end
        endcase

        // Leading edge starts an access; illegal spacing is ignored and flagged
        if (lead && r_reg.sel_lat)
        begin
            r_next.busy       = 1'b1;
            r_next.is_read    = rd_now;
            r_next.acc_addr   = r_reg.addr_lat;
            r_next.ok         = legal && !(rd_now && r_reg.cfg[CFG_RBT_BIT]);
            r_next.since_lead = 3'h0;
            if (rd_now && r_reg.addr_lat == REG_STATUS && legal)
            begin
                r_next.viol = 1'b0;
            end
            if (!legal)
            begin
                r_next.viol = 1'b1;
            end
            if (rd_now && r_next.ok)
            begin
                r_next.dout = reg_read(r_reg.addr_lat, r_reg);
                if (r_reg.addr_lat == REG_DATA)
                begin
                    r_next.pend_rd = 1'b1;
                    if (r_reg.autoinc)
                    begin
                        r_next.ptr = r_reg.ptr + 11'h001;
                    end
                end
            end
        end

        // Trailing edge completes the access; writes use the data seen before it
        if (trail && r_reg.busy)
        begin
            r_next.busy        = 1'b0;
            r_next.since_trail = 3'h0;
            r_next.last_data   = r_reg.ok && r_reg.acc_addr == REG_DATA;
            r_next.last_lo_wr  = r_reg.ok && !r_reg.is_read && r_reg.acc_addr == REG_ADDR_LO;
            if (r_reg.ok && !r_reg.is_read)
            begin
                unique case (r_reg.acc_addr)
                    REG_ADDR_HI:
                    begin
                        r_next.ptr[10:8] = r_reg.ad_prev[2:0];
                        r_next.autoinc   = r_reg.ad_prev[HI_AUTOINC_BIT];
                    end
                    REG_ADDR_LO:
                    begin
                        r_next.ptr[7:0] = r_reg.ad_prev;
                        r_next.pend_rd  = 1'b1;
                    end
                    REG_DATA:
                    begin
                        r_next.pend_wr = 1'b1;
                        r_next.waddr   = r_reg.ptr;
                        r_next.wbyte   = r_reg.ad_prev;
                        r_next.pend_rd = 1'b1;
                        if (r_reg.autoinc)
                        begin
                            r_next.ptr = r_reg.ptr + 11'h001;
                        end
                    end
                    REG_CONFIG: r_next.cfg = r_reg.ad_prev;
                    default:    r_next.cfg = r_reg.cfg;
                endcase
            end
        end
    end

    // State register
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            r_reg             <= '0;
            r_reg.ale_prev    <= ale; // Track the pin so no false fall follows reset
            r_reg.since_lead  <= TARB_SAT;
            r_reg.since_trail <= TARB_SAT;
            r_reg.cfg         <= CONFIG_RST;
            r_reg.ptr         <= PTR_RST;
            r_reg.ram_st      <= RAM_IDLE;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    // Buffer memory
    port_ram u_ram
    (
        .clk   (clk),
        .we    (ram_we),
        .addr  (ram_addr),
        .wdata (r_reg.wbyte),
        .rdata (ram_rdata)
    );

endmodule : muxed_host_bus_access_port

// ### verif/port_sva.sv
// Pin-level assertions for the host bus port
`timescale 1ns/1ps
module port_sva
(
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       ale,
    input  wire logic       chip_select_n,
    input  wire logic [7:0] ad_out,
    input  wire logic       ad_oe,
    input  wire logic       data_strobe_mode,
    input  wire logic       data_strobe_n,
    input  wire logic       dir,
    input  wire logic       read_strobe_n
);
    logic       rd_act;
    logic       ale_reg;
    logic       cs_reg;
    logic       oe_reg;
    logic [3:0] gap_reg;

    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    // Read strobe as seen on the pins
    assign rd_act = data_strobe_mode ? (!data_strobe_n && dir) : !read_strobe_n;

    // Latched select and clocks since the last drive start
    always_ff @(posedge clk)
    begin
        ale_reg <= ale;
        oe_reg  <= ad_oe;
        if (ale_reg && !ale)
            cs_reg <= chip_select_n;
        if (srst)
            gap_reg <= 4'hF;
        else if (ad_oe && !oe_reg)
            gap_reg <= 4'h0;
        else if (gap_reg != 4'hF)
            gap_reg <= gap_reg + 4'h1;
    end

    a_oe_read_only: assert property (ad_oe |-> rd_act)
        else $error("Drive without read strobe");
    a_oe_late_rise: assert property ($rose(ad_oe) |-> $past(rd_act) && !$past(rd_act, 2))
        else $error("Drive start not one cycle after strobe");
    a_oe_holds: assert property ($rose(ad_oe) ##1 rd_act |-> ad_oe)
        else $error("Drive dropped while strobe held");
    a_out_hold: assert property (ad_oe && $past(ad_oe) |-> $stable(ad_out))
        else $error("Read data moved while driven");
    a_out_stands: assert property ($changed(ad_out) && !$past(srst) |-> $rose(ad_oe))
        else $error("Read data changed without a read");
    a_reset_quiet: assert property ($fell(srst) |-> !ad_oe && ad_out == 8'h00)
        else $error("Bus not quiet after reset");
    a_cs_gate: assert property (ad_oe |-> !cs_reg)
        else $error("Drive while not selected");
    a_read_spacing: assert property (ad_oe && !oe_reg |-> gap_reg >= 4'h9)
        else $error("Reads accepted too close");
endmodule : port_sva

bind muxed_host_bus_access_port port_sva i_sva (.clk, .srst, .ale, .chip_select_n, .ad_out,
    .ad_oe, .data_strobe_mode, .data_strobe_n, .dir, .read_strobe_n);

// ### verif/host_model.sv
// Microcontroller model driving the multiplexed bus
`timescale 1ns/1ps
module host_model
(
    input  wire logic       clk,
    input  wire logic       mode,
    input  wire logic [7:0] ad_out,
    input  wire logic       ad_oe,
    output logic            ale,
    output logic            chip_select_n,
    output logic [7:0]      ad_in,
    output logic            data_strobe_n,
    output logic            dir,
    output logic            read_strobe_n,
    output logic            write_strobe_n
);
    logic [7:0] hv = 8'h00;
    logic       hd = 1'b0;
    logic [7:0] rd;
    logic       seen;

    // Wire level: host, else device, else inverse of the last host value
    assign ad_in = hd ? hv : (ad_oe ? ad_out : ~hv);

    // Idle bus at time zero
    initial
    begin
        ale = 1'b0;
        chip_select_n = 1'b1;
        data_strobe_n = 1'b1;
        dir = 1'b0;
        read_strobe_n = 1'b1;
        write_strobe_n = 1'b1;
    end

    // One bus cycle after gap idle clocks
    task automatic acc(input logic wr, input logic [2:0] a, input logic [7:0] d, input int gap);
        repeat (gap) @(posedge clk);
        ale <= 1'b1;
        chip_select_n <= 1'b0;
        hv <= {5'h00, a};
        hd <= 1'b1;
        @(posedge clk);
        ale <= 1'b0;
        @(posedge clk);
        hv <= d;
        hd <= wr;
        dir <= !wr;
        @(posedge clk);
        data_strobe_n <= !mode;
        read_strobe_n <= mode | wr;
        write_strobe_n <= mode | !wr;
        repeat (12) @(posedge clk);
        rd = ad_in;
        seen = ad_oe;
        data_strobe_n <= 1'b1;
        read_strobe_n <= 1'b1;
        write_strobe_n <= 1'b1;
        @(posedge clk);
        hd <= 1'b0;
        chip_select_n <= 1'b1;
    endtask : acc
endmodule : host_model

// ### verif/test_muxed_host_bus_access_port.sv
// Self-checking bench for the multiplexed host bus port
`timescale 1ns/1ps
module test_muxed_host_bus_access_port;
    import host_port_pkg::*;
    localparam int G = 60;
    logic       clk = 1'b0;
    logic       srst = 1'b1;
    logic       mode = 1'b0;
    logic       ale;
    logic       chip_select_n;
    logic [7:0] ad_in;
    logic [7:0] ad_out;
    logic       ad_oe;
    logic       data_strobe_n;
    logic       dir;
    logic       read_strobe_n;
    logic       write_strobe_n;
    int         failures = 0;
    int         checks = 0;

    always #2.5 clk = ~clk;

    muxed_host_bus_access_port i_dut (.clk, .srst, .ale, .chip_select_n, .ad_in, .ad_out,
        .ad_oe, .data_strobe_mode(mode), .data_strobe_n, .dir, .read_strobe_n, .write_strobe_n);
    host_model i_host (.clk, .mode, .ad_out, .ad_oe, .ale, .chip_select_n, .ad_in,
        .data_strobe_n, .dir, .read_strobe_n, .write_strobe_n);

    task automatic test_done;
        if (failures == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : test_done

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [2:0] a, input logic [7:0] d, input int gap);
        i_host.acc(1'b1, a, d, gap);
    endtask : wr

    // Read; oe says whether the port must answer
    task automatic rd(input logic [2:0] a, input int gap, input logic [7:0] exp, input logic oe);
        i_host.acc(1'b0, a, 8'h00, gap);
        chk("drive", {7'h00, i_host.seen}, {7'h00, oe});
        if (oe)
            chk("data", i_host.rd, exp);
    endtask : rd

    // Watchdog
    initial
    begin
        repeat (20000) @(posedge clk);
        failures++;
        test_done();
    end

    // Main sequence
    initial
    begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        chk("idle oe", {7'h00, ad_oe}, 8'h00);
        chk("idle out", ad_out, 8'h00);
        rd(REG_CONFIG, 0, CONFIG_RST, 1'b1);
        rd(REG_STATUS, G, 8'h00, 1'b1);
        wr(REG_ADDR_HI, 8'h80, G);
        wr(REG_ADDR_LO, 8'h10, G);
        wr(REG_DATA, 8'hA5, G);
        wr(REG_DATA, 8'h5A, G);
        wr(REG_ADDR_LO, 8'h10, G);
        rd(REG_DATA, G, 8'hA5, 1'b1);
        rd(REG_DATA, G, 8'h5A, 1'b1);
        rd(REG_ADDR_LO, G, 8'h12, 1'b1);
        wr(REG_DATA, 8'h77, G);
        rd(REG_ADDR_LO, 36, 8'h00, 1'b0);
        rd(REG_STATUS, G, 8'h01, 1'b1);
        rd(REG_STATUS, G, 8'h00, 1'b1);
        rd(REG_ADDR_HI, G, 8'h80, 1'b1);
        wr(REG_ADDR_LO, 8'h12, G);
        rd(REG_DATA, G, 8'h77, 1'b1);
        wr(REG_ADDR_LO, 8'h10, 36);
        rd(REG_ADDR_LO, G, 8'h13, 1'b1);
        wr(REG_DATA, 8'h99, G);
        wr(REG_ADDR_LO, 8'h10, 36);
        rd(REG_ADDR_LO, G, 8'h14, 1'b1);
        wr(REG_ADDR_LO, 8'h10, G);
        rd(REG_DATA, G, 8'hA5, 1'b1);
        rd(REG_ADDR_HI, 36, 8'h00, 1'b0);
        wr(REG_ADDR_LO, 8'h10, G);
        rd(REG_STATUS, 20, 8'h00, 1'b0);
        rd(REG_STATUS, 2, 8'h00, 1'b0);
        rd(REG_STATUS, G, 8'h01, 1'b1);
        wr(REG_CONFIG, 8'h01, G);
        rd(REG_CONFIG, G, 8'h00, 1'b0);
        wr(REG_CONFIG, 8'h02, G);
        rd(REG_CONFIG, 130, 8'h02, 1'b1);
        rd(REG_CONFIG, 40, 8'h00, 1'b0);
        wr(REG_CONFIG, 8'h08, 130);
        rd(REG_CONFIG, 20, 8'h08, 1'b1);
        mode <= 1'b1;
        wr(REG_ADDR_LO, 8'h10, G);
        rd(REG_DATA, G, 8'hA5, 1'b1);
        wr(REG_DATA, 8'h3C, G);
        wr(REG_ADDR_LO, 8'h11, G);
        rd(REG_DATA, G, 8'h3C, 1'b1);
        test_done();
    end
endmodule : test_muxed_host_bus_access_port
